// file: wdt_map.svh
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define WDT_OFS_CTRL 8'h00
`define WDT_OFS_CTRL_CLR 8'h04
`define WDT_OFS_CTRL_SET 8'h08
`define WDT_OFS_CTRL_INV 8'h0c
`define WDT_OFS_INT_STAT 8'h10
`define WDT_OFS_INT_MASK 8'h14

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define WDT_BIT_ON 15
`define WDT_BIT_PS_LSB 2
`define WDT_BIT_PS_MSB 6
`define WDT_BIT_WIN 1
`define WDT_BIT_CLR 0
`define WDT_CTRL_WMASK 32'h0000_8003
`define WDT_RST_CTRL 32'h0000_0000
`define WDT_EV_TIMEOUT 0
`define WDT_EV_WINFAULT 1
`define WDT_NUM_EV 2
`define WDT_RST_MASK 2'h0

// ****************************************************************
// Timing
// ****************************************************************
`define WDT_WIN_SHIFT 2
`define WDT_PULSE_CYCLES 4'h1

`endif

// file: wdt_pkg.sv
package wdt_pkg;

	typedef enum logic [1:0] {
		WDT_ST_OFF,
		WDT_ST_RUN,
		WDT_ST_FIRE
	} wdt_state_t;

	typedef enum logic [1:0] {
		WDT_AL_BASE,
		WDT_AL_CLR,
		WDT_AL_SET,
		WDT_AL_INV
	} wdt_alias_t;

endpackage

// file: wdt_evt_if.sv
`timescale 1ns/1ns
`include "wdt_map.svh"

interface wdt_evt_if;
	logic tick;
	logic [`WDT_NUM_EV-1:0] ev;
	logic [`WDT_NUM_EV-1:0] w1c;
	logic mask_we;
	logic [`WDT_NUM_EV-1:0] mask_d;
	logic [`WDT_NUM_EV-1:0] stat;
	logic [`WDT_NUM_EV-1:0] mask;
	logic irq;

	modport tick_src (
		output tick
	);

	modport irq_side (
		input ev,
		input w1c,
		input mask_we,
		input mask_d,
		output stat,
		output mask,
		output irq
	);

	modport core (
		input tick,
		output ev,
		output w1c,
		output mask_we,
		output mask_d,
		input stat,
		input mask,
		input irq
	);
endinterface

// file: wdt_tick.sv
`timescale 1ns/1ns

module wdt_tick (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic low_power_rc_clock_i,
	wdt_evt_if.tick_src evt
);

	logic rc_prev_r;
	logic tick_r;

	// ****************************************************************
	// Slow clock edge detect
	// ****************************************************************
	// The slow oscillator is sampled, so its period must exceed two
	// system clocks for every edge to be seen.
	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			rc_prev_r <= 1'h0;
			tick_r <= 1'h0;
		end
		else
		begin
			rc_prev_r <= low_power_rc_clock_i;
			tick_r <= low_power_rc_clock_i & ~rc_prev_r;
		end
	end

	assign evt.tick = tick_r;

endmodule // wdt_tick

// file: wdt_irq.sv
`timescale 1ns/1ns
`include "wdt_map.svh"

module wdt_irq (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	wdt_evt_if.irq_side evt
);

	logic [`WDT_NUM_EV-1:0] stat_r;
	logic [`WDT_NUM_EV-1:0] mask_r;
	logic irq_r;

	// ****************************************************************
	// Sticky status
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < `WDT_NUM_EV; g++)
		begin : g_stat
			// A new event beats a clear in the same cycle.
			always_ff @(posedge sys_clk_i)
			begin
				if (!nrst_i)
					stat_r[g] <= 1'h0;
				else if (evt.ev[g])
					stat_r[g] <= 1'h1;
				else if (evt.w1c[g])
					stat_r[g] <= 1'h0;
			end
		end
	endgenerate

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			mask_r <= `WDT_RST_MASK;
		else if (evt.mask_we)
			mask_r <= evt.mask_d;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			irq_r <= 1'h0;
		else
			irq_r <= |(stat_r & mask_r);
	end

	assign evt.stat = stat_r;
	assign evt.mask = mask_r;
	assign evt.irq = irq_r;

endmodule // wdt_irq

// file: wdt_core.sv
`timescale 1ns/1ns
`include "wdt_map.svh"

// Function
// - Counter advances only on edges of the slow RC oscillator.
// - Running watchdog resets the device if not cleared before time-out.
// - Time-out length is chosen by a postscaler code.
// - Time-out during sleep or idle wakes the device instead.
// - Writing one to bit 15 starts the watchdog.
// - Writing zero stops only a software-enabled watchdog.
// - Bit 15 reads one whenever the watchdog runs.
// - Bits 6 to 2 shadow the configured postscaler, loaded at reset.
// - Bit 1 selects windowed mode; reset value zero.
// - Writing one to bit 0 clears the counter.
// - Writing zero to bit 0 does nothing.
// - Clear, set and invert aliases sit at offsets 4, 8 and 12.
// - Unused control bits read zero and ignore writes.
module wdt_core (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic low_power_rc_clock_i,
	input wire logic cfg_enable_i,
	input wire logic [4:0] configured_postscale_i,
	input wire logic sleep_idle_i,
	output logic dev_reset_o,
	output logic wake_o,
	output logic irq_o
);

	wdt_evt_if evt ();

	wdt_pkg::wdt_state_t state_r;
	wdt_pkg::wdt_state_t state_nxt;
	wdt_pkg::wdt_alias_t alias_w;

	logic sw_on_r;
	logic win_r;
	logic [4:0] postscale_shadow_r;
	logic [31:0] cnt_r;
	logic [31:0] limit_w;
	logic [31:0] open_w;
	logic running_w;
	logic [31:0] ctrl_rd_w;
	logic [31:0] ctrl_nxt;
	logic ctrl_we_w;
	logic clr_req_w;
	logic early_w;
	logic expire_w;
	logic dev_reset_r;
	logic wake_r;
	logic [31:0] rdata_r;

	localparam logic [31:0] ctrl_rst_val = `WDT_RST_CTRL;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	wdt_tick u_tick (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.low_power_rc_clock_i(low_power_rc_clock_i),
		.evt(evt.tick_src)
	);

	wdt_irq u_irq (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.evt(evt.irq_side)
	);

	// ****************************************************************
	// Control register view and alias decode
	// ****************************************************************
	assign running_w = cfg_enable_i | sw_on_r;

	always_comb
	begin
		ctrl_rd_w = 32'h0000_0000;
		ctrl_rd_w[`WDT_BIT_ON] = running_w;
		ctrl_rd_w[`WDT_BIT_PS_MSB:`WDT_BIT_PS_LSB] = postscale_shadow_r;
		ctrl_rd_w[`WDT_BIT_WIN] = win_r;
	end

	always_comb
	begin
		alias_w = wdt_pkg::WDT_AL_BASE;
		ctrl_we_w = 1'h0;
		unique case (addr_i)
			`WDT_OFS_CTRL:
			begin
				alias_w = wdt_pkg::WDT_AL_BASE;
				ctrl_we_w = wr_i;
			end
			`WDT_OFS_CTRL_CLR:
			begin
				alias_w = wdt_pkg::WDT_AL_CLR;
				ctrl_we_w = wr_i;
			end
			`WDT_OFS_CTRL_SET:
			begin
				alias_w = wdt_pkg::WDT_AL_SET;
				ctrl_we_w = wr_i;
			end
			`WDT_OFS_CTRL_INV:
			begin
				alias_w = wdt_pkg::WDT_AL_INV;
				ctrl_we_w = wr_i;
			end
			default:
			begin
				alias_w = wdt_pkg::WDT_AL_BASE;
				ctrl_we_w = 1'h0;
			end
		endcase
	end

	// The ON bit as read stays set under configuration enable, so an
	// alias clear or invert sets the software request unless its data has bit 15, which drops it.
	always_comb
	begin
		unique case (alias_w)
			wdt_pkg::WDT_AL_BASE: ctrl_nxt = wdata_i;
			wdt_pkg::WDT_AL_CLR: ctrl_nxt = ctrl_rd_w & ~wdata_i;
			wdt_pkg::WDT_AL_SET: ctrl_nxt = ctrl_rd_w | wdata_i;
			wdt_pkg::WDT_AL_INV: ctrl_nxt = ctrl_rd_w ^ wdata_i;
		endcase
	end

	// Bit 0 always reads zero, so only a one in the result clears.
	assign clr_req_w = ctrl_we_w & ctrl_nxt[`WDT_BIT_CLR];

	// ****************************************************************
	// Control fields
	// ****************************************************************
	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			sw_on_r <= ctrl_rst_val[`WDT_BIT_ON];
		else if (ctrl_we_w)
			sw_on_r <= ctrl_nxt[`WDT_BIT_ON];
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			win_r <= ctrl_rst_val[`WDT_BIT_WIN];
		else if (ctrl_we_w)
			win_r <= ctrl_nxt[`WDT_BIT_WIN];
	end

	// The shadow is read-only and is refreshed only by reset.
	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			postscale_shadow_r <= configured_postscale_i;
	end

	// ****************************************************************
	// Time-out and window
	// ****************************************************************
	assign limit_w = 32'h0000_0001 << postscale_shadow_r;
	// The window opens for the last quarter of the period.
	assign open_w = limit_w - (limit_w >> `WDT_WIN_SHIFT);
	assign early_w = clr_req_w & win_r & (cnt_r < open_w);
	assign expire_w = evt.tick & (cnt_r == limit_w - 32'h0000_0001);

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			wdt_pkg::WDT_ST_OFF:
			begin
				if (running_w)
					state_nxt = wdt_pkg::WDT_ST_RUN;
			end
			wdt_pkg::WDT_ST_RUN:
			begin
				if (!running_w)
					state_nxt = wdt_pkg::WDT_ST_OFF;
				else if (early_w || (expire_w && !clr_req_w))
					state_nxt = wdt_pkg::WDT_ST_FIRE;
			end
			wdt_pkg::WDT_ST_FIRE:
			begin
				state_nxt = running_w ? wdt_pkg::WDT_ST_RUN :
					wdt_pkg::WDT_ST_OFF;
			end
			default:
			begin
				state_nxt = wdt_pkg::WDT_ST_OFF;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			state_r <= wdt_pkg::WDT_ST_OFF;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			cnt_r <= 32'h0000_0000;
		else if (state_r != wdt_pkg::WDT_ST_RUN || clr_req_w)
			cnt_r <= 32'h0000_0000;
		else if (expire_w)
			cnt_r <= 32'h0000_0000;
		else if (evt.tick)
			cnt_r <= cnt_r + 32'h0000_0001;
	end

	// ****************************************************************
	// Reset and wake outputs
	// ****************************************************************
	// In sleep a time-out only wakes; a window fault still resets,
	// since it shows software ran when it should not have.
	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			dev_reset_r <= 1'h0;
		else
			dev_reset_r <= state_nxt == wdt_pkg::WDT_ST_FIRE &&
				(early_w || !sleep_idle_i);
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			wake_r <= 1'h0;
		else
			wake_r <= state_nxt == wdt_pkg::WDT_ST_FIRE && !early_w &&
				sleep_idle_i;
	end

	// Status follows the firing decision, so a write that also drops the
	// enable never leaves a fault flagged without a reset or wake behind it.
	assign evt.ev[`WDT_EV_TIMEOUT] = state_nxt == wdt_pkg::WDT_ST_FIRE &&
		!early_w;
	assign evt.ev[`WDT_EV_WINFAULT] = state_nxt == wdt_pkg::WDT_ST_FIRE &&
		early_w;

	// ****************************************************************
	// Interrupt registers
	// ****************************************************************
	assign evt.w1c = (wr_i && addr_i == `WDT_OFS_INT_STAT) ?
		wdata_i[`WDT_NUM_EV-1:0] : 2'h0;
	assign evt.mask_we = wr_i && addr_i == `WDT_OFS_INT_MASK;
	assign evt.mask_d = wdata_i[`WDT_NUM_EV-1:0];

	// ****************************************************************
	// Read port
	// ****************************************************************
	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			rdata_r <= 32'h0000_0000;
		else if (!rd_i)
			rdata_r <= 32'h0000_0000;
		else
		begin
			unique case (addr_i)
				`WDT_OFS_CTRL,
				`WDT_OFS_CTRL_CLR,
				`WDT_OFS_CTRL_SET,
				`WDT_OFS_CTRL_INV:
					rdata_r <= ctrl_rd_w;
				`WDT_OFS_INT_STAT:
					rdata_r <= {30'h0, evt.stat};
				`WDT_OFS_INT_MASK:
					rdata_r <= {30'h0, evt.mask};
				default:
					rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	assign rdata_o = rdata_r;
	assign dev_reset_o = dev_reset_r;
	assign wake_o = wake_r;
	assign irq_o = evt.irq;

endmodule // wdt_core

// file: wdt_core_asserts.sv
`timescale 1ns/1ns

// ****************
// Port checker
// ****************
module wdt_core_chk (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic cfg_enable_i,
	input wire logic [4:0] configured_postscale_i,
	input wire logic sleep_idle_i,
	input wire logic dev_reset_o,
	input wire logic wake_o
);
	logic [4:0] ps_r;

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);

	// The shadow must match what reset itself captured, not a later pin.
	always_ff @(posedge sys_clk_i)
		if (!nrst_i)
			ps_r <= configured_postscale_i;

	sequence rd_ctl_s;
		rd_i && addr_i == 8'h00;
	endsequence
	sequence set_win_s;
		wr_i && addr_i == 8'h08 && wdata_i[1];
	endsequence
	sequence clr_win_s;
		wr_i && addr_i == 8'h04 && wdata_i[1];
	endsequence

	unused_zero_a: assert property (rdata_o[31:16] == 16'h0
		&& rdata_o[14:7] == 8'h0) else $error("unused bits set");
	clr_reads_zero_a: assert property (rd_ctl_s |=> !rdata_o[0])
		else $error("clear bit read one");
	on_reads_cfg_a: assert property (rd_ctl_s ##0
		(cfg_enable_i && $past(cfg_enable_i)) |=> rdata_o[15])
		else $error("enable bit reads zero");
	shadow_copy_a: assert property (rd_ctl_s |=>
		rdata_o[6:2] == ps_r) else $error("shadow wrong");
	set_alias_a: assert property (set_win_s ##1 rd_ctl_s |=>
		rdata_o[1]) else $error("set alias lost");
	clr_alias_a: assert property (clr_win_s ##1 rd_ctl_s |=>
		!rdata_o[1]) else $error("clear alias lost");
	reset_pulse_a: assert property (dev_reset_o |=> !dev_reset_o)
		else $error("reset pulse too long");
	wake_sleep_a: assert property (wake_o |->
		$past(sleep_idle_i) && !dev_reset_o) else $error("wake wrong");
endmodule // wdt_core_chk

// file: tb.sv
`timescale 1ns/1ns

// ****************
// Bench
// ****************
module tb;
	logic sys_clk_i = 1'h0;
	logic nrst_i = 1'h0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'h0;
	logic rd_i = 1'h0;
	logic rc = 1'h0;
	logic cfg_enable_i = 1'h0;
	logic [4:0] ps = 5'h00;
	logic sleep_idle_i = 1'h0;
	logic [31:0] rdata_o;
	logic dev_reset_o;
	logic wake_o;
	logic irq_o;
	logic [31:0] seed = 32'h55fe55d2;
	logic [7:0] al [4] = '{8'h08, 8'h04, 8'h0c, 8'h0c};
	logic w;
	int errors = 0;
	int n_tests = 0;
	int n_rst = 0;
	int n_wake = 0;
	int r0 = 0;
	int w0 = 0;
	int cyc = 0;

	wdt_core u_wdt_core (
		.sys_clk_i,
		.nrst_i,
		.addr_i,
		.wdata_i,
		.wr_i,
		.rd_i,
		.rdata_o,
		.low_power_rc_clock_i(rc),
		.cfg_enable_i,
		.configured_postscale_i(ps),
		.sleep_idle_i,
		.dev_reset_o,
		.wake_o,
		.irq_o
	);

	always #10 sys_clk_i = ~sys_clk_i;

	// Pulses are counted mid-cycle, away from the edge that launches them.
	always @(negedge sys_clk_i)
	begin
		cyc++;
		// An unknown counts as a pulse, so it can never pass as quiet.
		n_rst += (dev_reset_o !== 1'h0);
		n_wake += (wake_o !== 1'h0);
		if (cyc == 6000)
		begin
			errors++;
			give_verdict;
		end
	end

	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [31:0] ctl(input logic on, input logic wn);
		return {16'h0, on, 8'h0, ps, wn, 1'h0};
	endfunction

	function automatic int lim(input logic [4:0] p);
		return 1 << p;
	endfunction

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, s);
		end
	endtask

	task give_verdict;
		$display("tests %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Two writes in a row get an idle edge so the strobe is set once a step.
	task wr(input logic [7:0] a, input logic [31:0] dt);
		if (wr_i)
			@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= dt;
		wr_i <= 1'h1;
		@(posedge sys_clk_i);
		wr_i <= 1'h0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		addr_i <= a;
		rd_i <= 1'h1;
		@(posedge sys_clk_i);
		rd_i <= 1'h0;
		@(negedge sys_clk_i);
		chk("rdata", rdata_o, e);
		@(posedge sys_clk_i);
	endtask

	task rcp(input int n);
		repeat (n)
		begin
			rc <= 1'h1;
			repeat (3) @(posedge sys_clk_i);
			rc <= 1'h0;
			repeat (3) @(posedge sys_clk_i);
		end
	endtask

	task ev(input int er, input int ew);
		repeat (3) @(posedge sys_clk_i);
		chk("resets", n_rst - r0, er);
		chk("wakes", n_wake - w0, ew);
		r0 = n_rst;
		w0 = n_wake;
	endtask

	task rst(input logic [4:0] p);
		nrst_i <= 1'h0;
		ps <= p;
		repeat (6) @(posedge sys_clk_i);
		nrst_i <= 1'h1;
		@(posedge sys_clk_i);
		r0 = n_rst;
		w0 = n_wake;
	endtask

	initial
	begin
		rst(seed[4:0]);
		rd(8'h00, ctl(1'h0, 1'h0));
		rd(8'h10, 32'h0);
		rd(8'h20, 32'h0);
		cfg_enable_i <= 1'h1;
		@(posedge sys_clk_i);
		repeat (6)
		begin
			seed = nxt(seed);
			wr(8'h00, seed);
			if (!seed[15])
				@(posedge sys_clk_i);
			rd(8'h00, ctl(1'h1, seed[1]));
		end
		w = seed[1];
		for (int i = 0; i < 4; i++)
		begin
			w = (i == 0) ? 1'h1 : (i == 1) ? 1'h0 : ~w;
			wr(al[i], 32'h2);
			rd(8'h00, ctl(1'h1, w));
		end
		wr(8'h00, 32'h0);
		@(posedge sys_clk_i);
		rd(8'h00, ctl(1'h1, 1'h0));
		cfg_enable_i <= 1'h0;
		@(posedge sys_clk_i);
		rd(8'h00, ctl(1'h0, 1'h0));
		rst(5'h02);
		rcp(8);
		ev(0, 0);
		wr(8'h00, 32'h8000);
		rcp(lim(ps) - 1);
		ev(0, 0);
		rcp(1);
		ev(1, 0);
		rcp(3);
		wr(8'h00, 32'h8001);
		rcp(3);
		ev(0, 0);
		wr(8'h00, 32'h8000);
		rcp(1);
		ev(1, 0);
		sleep_idle_i <= 1'h1;
		rcp(4);
		ev(0, 1);
		sleep_idle_i <= 1'h0;
		wr(8'h08, 32'h2);
		wr(8'h08, 32'h1);
		ev(1, 0);
		rcp(3);
		wr(8'h08, 32'h1);
		ev(0, 0);
		chk("irq", irq_o, 32'h0);
		wr(8'h14, 32'h3);
		repeat (2) @(posedge sys_clk_i);
		chk("irq", irq_o, 32'h1);
		rd(8'h10, 32'h3);
		wr(8'h10, 32'h3);
		repeat (2) @(posedge sys_clk_i);
		chk("irq", irq_o, 32'h0);
		// A longer period shows the ratio doubles rather than grows by steps.
		rst(5'h03);
		wr(8'h00, 32'h8000);
		rcp(lim(ps) - 1);
		ev(0, 0);
		rcp(1);
		ev(1, 0);
		give_verdict;
	end
endmodule // tb

bind wdt_core wdt_core_chk u_wdt_core_chk (
	.sys_clk_i,
	.nrst_i,
	.addr_i,
	.wdata_i,
	.wr_i,
	.rd_i,
	.rdata_o,
	.cfg_enable_i,
	.configured_postscale_i,
	.sleep_idle_i,
	.dev_reset_o,
	.wake_o
);
